// ===== tdp_regs.vh
// Constants of the target disconnect policy block: page layout, codes, timing.
// Assumes a 200 MHz core clock and page bytes delivered one index at a time.
`ifndef TDP_REGS_VH
`define TDP_REGS_VH

// Page codes and page lengths
`define TDP_PG_DISC        6'h02
`define TDP_PG_LUCTL       6'h18
`define TDP_PG_PORT        6'h19
`define TDP_LEN_DISC       8'h0E
`define TDP_LEN_SHORT      8'h06
`define TDP_PROTO_ID       4'h1

// Byte indices of the disconnect-reconnect page
`define TDP_OFS_HEADER     4'h0
`define TDP_OFS_SIZE       4'h1
`define TDP_OFS_FILL       4'h2
`define TDP_OFS_DRAIN      4'h3
`define TDP_OFS_IDLE       4'h4
`define TDP_OFS_RECON      4'h6
`define TDP_OFS_OCCUP      4'h8
`define TDP_OFS_BURST      4'hA
`define TDP_OFS_FLAGS      4'hC

// Byte indices of the port control page
`define TDP_OFS_PROTO      4'h3
`define TDP_OFS_STT        4'h4

// Field positions in the flags byte
`define TDP_BIT_PMOD       7
`define TDP_BIT_IMMED      3
`define TDP_TDC_HI         2
`define TDP_TDC_LO         0

// Transfer disconnect control codes
`define TDP_TDC_OFF        3'h0
`define TDP_TDC_DATA       3'h1
`define TDP_TDC_CMD        3'h3

// Special timeout values
`define TDP_STT_OFF        16'h0000
`define TDP_STT_FOREVER    16'hFFFF

// Reset values
`define TDP_RST_BYTE       8'h00
`define TDP_RST_WORD       16'h0000
`define TDP_PS_DEFAULT     1'b0

// Timing: limit unit in microseconds, clock in MHz, units per millisecond
`define TDP_UNIT_US        100
`define TDP_CLK_MHZ        200
`define TDP_UNIT_CYC       16'h4E20
`define TDP_MS_UNITS       4'hA
`define TDP_BURST_SHIFT    9

`endif

// ===== tdp_core.v
// Disconnect and reconnect policy of a parallel bus target, with its mode pages.
// Assumes phase, byte and bus-ownership strobes come from target logic on
// i_core_clk; REQ and ACK arrive from the bus pins and are synchronised here.
//
// What this block does
// - Reject a disconnect page write with non-zero undefined fields as illegal.
// - Disconnect when busy idle time reaches inactivity limit; zero means none.
// - Wait at least the reconnect minimum after release before reconnecting.
// - Disconnect once connect time limit is reached, when privileged and allowed.
// - Disconnect after the burst quota of 512-byte units in a data phase.
// - Pointer-modify messages only allowed while the enable bit is one.
// - Rejected pointer-modify message with enable set ends command as aborted.
// - Immediate-disconnect bit forces a disconnect between command and data.
// - Control 001b holds connection from data start until all data moved.
// - Control 011b holds connection from data start until command completes.
// - Control 000b defers to other fields; codes 010b and 1xxb are reserved.
// - Non-zero transfer control together with non-zero burst quota is illegal.
// - Disconnect page reports code 02h and length 0Eh.
// - Logical unit control page 18h, length 06h, holds only reserved bytes.
// - Port control page exists on logical unit zero only.
// - Port control page reports protocol 1h and a 16-bit transfer timeout.
// - Timeout counts milliseconds, forces bus free; 0000h off, FFFFh unlimited.
// - REQ with none outstanding starts timer; ACK reloads, stops when none left.
`timescale 1ns/1ps
`include "tdp_regs.vh"

module tdp_core #(
  parameter [15:0] P_UNIT_CYC = `TDP_UNIT_CYC
) (
  input  wire        i_core_clk,
  input  wire        i_rst_b,
  input  wire [2:0]  i_logical_unit_number,
  input  wire [5:0]  i_pg_code,
  input  wire        i_pg_wr,
  input  wire [3:0]  i_pg_idx,
  input  wire [7:0]  i_pg_wdata,
  input  wire        i_pg_commit,
  input  wire        i_pg_rd,
  output reg         o_sel_ok,
  output reg         o_sel_illegal,
  output reg  [7:0]  o_pg_rdata,
  output reg         o_pg_rvalid,
  output reg         o_pg_absent,
  input  wire        i_bsy_held,
  input  wire        i_priv_granted,
  input  wire        i_cmd_phase_done,
  input  wire        i_data_phase,
  input  wire        i_byte_xfer,
  input  wire        i_data_done,
  input  wire        i_cmd_done,
  input  wire        i_req_pin,
  input  wire        i_ack_pin,
  input  wire        i_mdp_rejected,
  output reg         o_disc_req,
  output reg         o_reconnect_ok,
  output reg         o_mdp_allow,
  output reg         o_mdp_abort,
  output reg         o_stt_bus_free
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Saturating increment of a 16-bit count
  function [15:0] sat_inc;
    input [15:0] v;
    begin
      sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    end
  endfunction

  // True when a non-zero limit has been reached
  function lim_hit;
    input [15:0] cnt;
    input [15:0] lim;
    begin
      lim_hit = (lim != `TDP_RST_WORD) && (cnt >= lim);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Page storage

  reg [7:0]  stage [0:15];
  reg [7:0]  fill_threshold_ratio;
  reg [7:0]  drain_threshold_ratio;
  reg [15:0] idle_hold_limit;
  reg [15:0] reconnect_wait_min;
  reg [15:0] occupancy_limit;
  reg [15:0] burst_quota;
  reg        pointer_modify_enable;
  reg        immediate_disconnect;
  reg [2:0]  transfer_disconnect_control;
  reg        parameters_savable;
  reg [15:0] stt_limit;
  integer    k;

  wire [2:0] stage_tdc   = stage[`TDP_OFS_FLAGS][`TDP_TDC_HI:`TDP_TDC_LO];
  wire [15:0] stage_bst  = {stage[`TDP_OFS_BURST], stage[`TDP_OFS_BURST + 4'h1]};
  wire       lun_zero    = (i_logical_unit_number == 3'h0);
  wire       disc_resv_ok = (stage[0][6] == 1'b0) &&
                            (stage[`TDP_OFS_FLAGS][6:4] == 3'h0) &&
                            (stage[13] == 8'h00) && (stage[14] == 8'h00) &&
                            (stage[15] == 8'h00);
  wire       tdc_code_ok = (stage_tdc == `TDP_TDC_OFF) || (stage_tdc == `TDP_TDC_DATA) ||
                           (stage_tdc == `TDP_TDC_CMD);
  wire       tdc_bst_ok  = (stage_tdc == `TDP_TDC_OFF) || (stage_bst == `TDP_RST_WORD);
  wire       disc_ok     = disc_resv_ok && tdc_code_ok && tdc_bst_ok;
  wire       luctl_ok    = (stage[2] == 8'h00) && (stage[3] == 8'h00) &&
                           (stage[4] == 8'h00) && (stage[5] == 8'h00) &&
                           (stage[6] == 8'h00) && (stage[7] == 8'h00);
  wire       port_ok     = lun_zero && (stage[2] == 8'h00) &&
                           (stage[`TDP_OFS_PROTO] == {4'h0, `TDP_PROTO_ID}) &&
                           (stage[6] == 8'h00) && (stage[7] == 8'h00);

  // Staging bytes collect one page image before it is checked
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (k = 0; k < 16; k = k + 1) begin
        stage[k] <= `TDP_RST_BYTE;
      end
    end else if (i_pg_commit) begin
      for (k = 0; k < 16; k = k + 1) begin
        stage[k] <= `TDP_RST_BYTE;
      end
    end else if (i_pg_wr) begin
      stage[i_pg_idx] <= i_pg_wdata;
    end
  end

  // Commit: check the image, then load live fields or refuse the select
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fill_threshold_ratio        <= `TDP_RST_BYTE;
      drain_threshold_ratio       <= `TDP_RST_BYTE;
      idle_hold_limit             <= `TDP_RST_WORD;
      reconnect_wait_min          <= `TDP_RST_WORD;
      occupancy_limit             <= `TDP_RST_WORD;
      burst_quota                 <= `TDP_RST_WORD;
      pointer_modify_enable       <= 1'b0;
      immediate_disconnect        <= 1'b0;
      transfer_disconnect_control <= `TDP_TDC_OFF;
      parameters_savable          <= `TDP_PS_DEFAULT;
      stt_limit                   <= `TDP_STT_OFF;
      o_sel_ok                    <= 1'b0;
      o_sel_illegal               <= 1'b0;
    end else begin
      o_sel_ok      <= 1'b0;
      o_sel_illegal <= 1'b0;
      if (i_pg_commit) begin
        if (i_pg_code == `TDP_PG_DISC && disc_ok) begin
          o_sel_ok                    <= 1'b1;
          fill_threshold_ratio        <= stage[`TDP_OFS_FILL];
          drain_threshold_ratio       <= stage[`TDP_OFS_DRAIN];
          idle_hold_limit             <= {stage[`TDP_OFS_IDLE], stage[`TDP_OFS_IDLE + 4'h1]};
          reconnect_wait_min          <= {stage[`TDP_OFS_RECON], stage[`TDP_OFS_RECON + 4'h1]};
          occupancy_limit             <= {stage[`TDP_OFS_OCCUP], stage[`TDP_OFS_OCCUP + 4'h1]};
          burst_quota                 <= stage_bst;
          pointer_modify_enable       <= stage[`TDP_OFS_FLAGS][`TDP_BIT_PMOD];
          immediate_disconnect        <= stage[`TDP_OFS_FLAGS][`TDP_BIT_IMMED];
          transfer_disconnect_control <= stage_tdc;
        end else if (i_pg_code == `TDP_PG_DISC) begin
          o_sel_illegal <= 1'b1;
        end else if (i_pg_code == `TDP_PG_LUCTL) begin
          o_sel_ok      <= luctl_ok;
          o_sel_illegal <= !luctl_ok;
        end else if (i_pg_code == `TDP_PG_PORT && port_ok) begin
          o_sel_ok  <= 1'b1;
          stt_limit <= {stage[`TDP_OFS_STT], stage[`TDP_OFS_STT + 4'h1]};
        end else begin
          o_sel_illegal <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page readback

  reg [7:0] next_rdata;
  reg       next_absent;

  // Byte image of the selected page
  always @* begin
    next_rdata  = `TDP_RST_BYTE;
    next_absent = 1'b0;
    if (i_pg_code == `TDP_PG_DISC) begin
      if (i_pg_idx == `TDP_OFS_HEADER) next_rdata = {parameters_savable, 1'b0, `TDP_PG_DISC};
      else if (i_pg_idx == `TDP_OFS_SIZE) next_rdata = `TDP_LEN_DISC;
      else if (i_pg_idx == `TDP_OFS_FILL) next_rdata = fill_threshold_ratio;
      else if (i_pg_idx == `TDP_OFS_DRAIN) next_rdata = drain_threshold_ratio;
      else if (i_pg_idx == 4'h4) next_rdata = idle_hold_limit[15:8];
      else if (i_pg_idx == 4'h5) next_rdata = idle_hold_limit[7:0];
      else if (i_pg_idx == 4'h6) next_rdata = reconnect_wait_min[15:8];
      else if (i_pg_idx == 4'h7) next_rdata = reconnect_wait_min[7:0];
      else if (i_pg_idx == 4'h8) next_rdata = occupancy_limit[15:8];
      else if (i_pg_idx == 4'h9) next_rdata = occupancy_limit[7:0];
      else if (i_pg_idx == 4'hA) next_rdata = burst_quota[15:8];
      else if (i_pg_idx == 4'hB) next_rdata = burst_quota[7:0];
      else if (i_pg_idx == `TDP_OFS_FLAGS)
        next_rdata = {pointer_modify_enable, 3'h0, immediate_disconnect,
                      transfer_disconnect_control};
    end else if (i_pg_code == `TDP_PG_LUCTL) begin
      if (i_pg_idx == `TDP_OFS_HEADER) next_rdata = {parameters_savable, 1'b0, `TDP_PG_LUCTL};
      else if (i_pg_idx == `TDP_OFS_SIZE) next_rdata = `TDP_LEN_SHORT;
    end else if (i_pg_code == `TDP_PG_PORT && lun_zero) begin
      if (i_pg_idx == `TDP_OFS_HEADER) next_rdata = {parameters_savable, 1'b0, `TDP_PG_PORT};
      else if (i_pg_idx == `TDP_OFS_SIZE) next_rdata = `TDP_LEN_SHORT;
      else if (i_pg_idx == `TDP_OFS_PROTO) next_rdata = {4'h0, `TDP_PROTO_ID};
      else if (i_pg_idx == 4'h4) next_rdata = stt_limit[15:8];
      else if (i_pg_idx == 4'h5) next_rdata = stt_limit[7:0];
    end else begin
      next_absent = 1'b1;
    end
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pg_rdata  <= `TDP_RST_BYTE;
      o_pg_rvalid <= 1'b0;
      o_pg_absent <= 1'b0;
    end else begin
      o_pg_rvalid <= i_pg_rd;
      if (i_pg_rd) begin
        o_pg_rdata  <= next_rdata;
        o_pg_absent <= next_absent;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick prescaler and pin synchronisers

  reg [15:0] pre_cnt;
  reg        unit_tick;
  reg [3:0]  ms_cnt;
  reg        ms_tick;
  reg [2:0]  req_s;
  reg [2:0]  ack_s;
  wire       req_edge = req_s[2] ^ req_s[1];
  wire       ack_edge = ack_s[2] ^ ack_s[1];

  // 100 us tick and 1 ms tick
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt   <= `TDP_RST_WORD;
      unit_tick <= 1'b0;
      ms_cnt    <= 4'h0;
      ms_tick   <= 1'b0;
      req_s     <= 3'h0;
      ack_s     <= 3'h0;
    end else begin
      req_s     <= {req_s[1:0], i_req_pin};
      ack_s     <= {ack_s[1:0], i_ack_pin};
      unit_tick <= (pre_cnt == P_UNIT_CYC - 16'h0001);
      pre_cnt   <= (pre_cnt == P_UNIT_CYC - 16'h0001) ? `TDP_RST_WORD : pre_cnt + 16'h0001;
      ms_tick   <= unit_tick && (ms_cnt == `TDP_MS_UNITS - 4'h1);
      if (unit_tick) begin
        ms_cnt <= (ms_cnt == `TDP_MS_UNITS - 4'h1) ? 4'h0 : ms_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Connection timers and disconnect decision

  reg [15:0] idle_cnt;
  reg [15:0] occ_cnt;
  reg [15:0] recon_cnt;
  reg [24:0] byte_cnt;
  reg        immed_pend;
  reg        hold_lock;
  reg        data_d;
  wire       data_start = i_data_phase && !data_d;
  wire [24:0] quota_bytes = {burst_quota, 9'h000};
  wire       burst_hit  = (burst_quota != `TDP_RST_WORD) && (byte_cnt >= quota_bytes);
  wire       limit_hit  = lim_hit(idle_cnt, idle_hold_limit) ||
                          lim_hit(occ_cnt, occupancy_limit);

  // Counters for idle, occupancy, release wait and burst bytes
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idle_cnt   <= `TDP_RST_WORD;
      occ_cnt    <= `TDP_RST_WORD;
      recon_cnt  <= `TDP_RST_WORD;
      byte_cnt   <= 25'h000_0000;
      immed_pend <= 1'b0;
      hold_lock  <= 1'b0;
      data_d     <= 1'b0;
    end else begin
      data_d <= i_data_phase;
      if (!i_bsy_held) begin
        idle_cnt   <= `TDP_RST_WORD;
        occ_cnt    <= `TDP_RST_WORD;
        byte_cnt   <= 25'h000_0000;
        immed_pend <= 1'b0;
        hold_lock  <= 1'b0;
        if (unit_tick) recon_cnt <= sat_inc(recon_cnt);
      end else begin
        recon_cnt <= `TDP_RST_WORD;
        if (req_edge || ack_edge) idle_cnt <= `TDP_RST_WORD;
        else if (unit_tick) idle_cnt <= sat_inc(idle_cnt);
        if (unit_tick) occ_cnt <= sat_inc(occ_cnt);
        if (data_start) byte_cnt <= 25'h000_0000;
        else if (i_byte_xfer && i_data_phase && byte_cnt != 25'h1FF_FFFF)
          byte_cnt <= byte_cnt + 25'h000_0001;
        if (i_cmd_phase_done && immediate_disconnect && i_priv_granted)
          immed_pend <= 1'b1;
        if (data_start && transfer_disconnect_control != `TDP_TDC_OFF)
          hold_lock <= 1'b1;
        else if (transfer_disconnect_control == `TDP_TDC_DATA && i_data_done)
          hold_lock <= 1'b0;
        else if (i_cmd_done)
          hold_lock <= 1'b0;
      end
    end
  end

  // Disconnect request holds until the bus is released
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_disc_req     <= 1'b0;
      o_reconnect_ok <= 1'b0;
    end else begin
      o_reconnect_ok <= !i_bsy_held &&
                        (reconnect_wait_min == `TDP_RST_WORD ||
                         recon_cnt >= reconnect_wait_min);
      if (!i_bsy_held) o_disc_req <= 1'b0;
      else if (i_priv_granted && !hold_lock &&
               (limit_hit || immed_pend || (burst_hit && i_data_phase)))
        o_disc_req <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer-modify permission

  // Permission level and abort pulse on a rejected message
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mdp_allow <= 1'b0;
      o_mdp_abort <= 1'b0;
    end else begin
      o_mdp_allow <= pointer_modify_enable;
      o_mdp_abort <= pointer_modify_enable && i_mdp_rejected;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous transfer timeout

  reg [7:0]  outstanding;
  reg [15:0] stt_cnt;
  reg        stt_run;
  wire       stt_armed = (stt_limit != `TDP_STT_OFF);

  // Outstanding REQ count and millisecond watchdog
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      outstanding    <= 8'h00;
      stt_cnt        <= `TDP_RST_WORD;
      stt_run        <= 1'b0;
      o_stt_bus_free <= 1'b0;
    end else begin
      o_stt_bus_free <= 1'b0;
      if (!i_bsy_held) begin
        outstanding <= 8'h00;
        stt_run     <= 1'b0;
      end else begin
        if (req_edge && !ack_edge && outstanding != 8'hFF) outstanding <= outstanding + 8'h01;
        else if (ack_edge && !req_edge && outstanding != 8'h00)
          outstanding <= outstanding - 8'h01;
        if (req_edge && outstanding == 8'h00) begin
          stt_run <= stt_armed;
          stt_cnt <= `TDP_RST_WORD;
        end else if (ack_edge && outstanding > 8'h01) begin
          stt_cnt <= `TDP_RST_WORD;
        end else if (ack_edge && outstanding != 8'h00 && !req_edge) begin
          stt_run <= 1'b0;
        end else if (stt_run && ms_tick) begin
          stt_cnt <= sat_inc(stt_cnt);
          if (stt_limit != `TDP_STT_FOREVER && sat_inc(stt_cnt) >= stt_limit) begin
            o_stt_bus_free <= 1'b1;
            stt_run        <= 1'b0;
          end
        end
      end
    end
  end

endmodule // tdp_core

// ===== tdp_core_monitor.sv
// Checker of tdp_core: page answers, disconnect requests, pointer and timeout events.
// Assumes one clock domain and an active-low asynchronous reset on the ports.
`timescale 1ns/1ps
`include "tdp_regs.vh"

module tdp_core_monitor #(
  parameter [15:0] P_UNIT_CYC = 16'h4e20
) (
  input wire       i_core_clk,
  input wire       i_rst_b,
  input wire [2:0] i_logical_unit_number,
  input wire [5:0] i_pg_code,
  input wire       i_pg_commit,
  input wire       i_pg_rd,
  input wire       o_sel_ok,
  input wire       o_sel_illegal,
  input wire       o_pg_rvalid,
  input wire       o_pg_absent,
  input wire       i_bsy_held,
  input wire       i_priv_granted,
  input wire       i_mdp_rejected,
  input wire       o_disc_req,
  input wire       o_reconnect_ok,
  input wire       o_mdp_allow,
  input wire       o_mdp_abort,
  input wire       o_stt_bus_free
);
  //////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // Steps that several properties build on
  sequence s_bus_held;
    i_bsy_held [*2];
  endsequence
  sequence s_mdp_refused;
    o_mdp_allow && i_mdp_rejected;
  endsequence
  sequence s_port_far_lun;
    i_pg_rd && i_pg_code == `TDP_PG_PORT && i_logical_unit_number != 3'h0;
  endsequence

  // One answer per commit, and never an answer without one
  a_commit_answer: assert property (i_pg_commit |=> o_sel_ok != o_sel_illegal)
    else $error("commit without single answer");
  a_answer_cause: assert property (o_sel_ok || o_sel_illegal |-> $past(i_pg_commit))
    else $error("answer without commit");
  // Reads answer next cycle; port page hidden away from unit zero
  a_read_answer: assert property (i_pg_rd |=> o_pg_rvalid)
    else $error("read not answered");
  a_port_lun_only: assert property (s_port_far_lun |=> o_pg_absent)
    else $error("port page offered off unit zero");
  // Pointer-modify rejection handling
  a_mdp_abort_on: assert property (s_mdp_refused |=> o_mdp_abort)
    else $error("rejected pointer message not aborted");
  a_mdp_abort_cause: assert property (o_mdp_abort |-> $past(i_mdp_rejected))
    else $error("abort without rejection");
  // Disconnect and reconnect relations
  a_disc_privileged: assert property ($rose(o_disc_req) |-> $past(i_priv_granted))
    else $error("disconnect without privilege");
  a_disc_release: assert property (!i_bsy_held |=> !o_disc_req)
    else $error("disconnect request kept after release");
  a_no_reconnect_held: assert property (s_bus_held |-> !o_reconnect_ok)
    else $error("reconnect allowed while bus held");
  a_stt_single: assert property (o_stt_bus_free |=> !o_stt_bus_free)
    else $error("bus free pulse too long");
endmodule // tdp_core_monitor

bind tdp_core tdp_core_monitor #(.P_UNIT_CYC(P_UNIT_CYC)) u_monitor (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_logical_unit_number(i_logical_unit_number), .i_pg_code(i_pg_code),
  .i_pg_commit(i_pg_commit), .i_pg_rd(i_pg_rd), .o_sel_ok(o_sel_ok),
  .o_sel_illegal(o_sel_illegal), .o_pg_rvalid(o_pg_rvalid), .o_pg_absent(o_pg_absent),
  .i_bsy_held(i_bsy_held), .i_priv_granted(i_priv_granted),
  .i_mdp_rejected(i_mdp_rejected), .o_disc_req(o_disc_req),
  .o_reconnect_ok(o_reconnect_ok), .o_mdp_allow(o_mdp_allow),
  .o_mdp_abort(o_mdp_abort), .o_stt_bus_free(o_stt_bus_free));

// ===== tdp_initiator_model.sv
// Initiator on the far side: answers REQ transitions with ACK, rejects messages.
// Assumes REQ arrives on the core clock; ACK is driven at all times.
`timescale 1ns/1ps

module tdp_initiator_model (
  input  wire       i_core_clk,
  input  wire       i_rst_b,
  input  wire       i_req_pin,
  input  wire       i_stall,
  input  wire [3:0] i_delay,
  input  wire       i_reject_cmd,
  input  wire       i_stray_reselect,
  output reg        o_ack_pin,
  output reg        o_mdp_rejected,
  output reg        o_abort_task
);
  reg        req_seen;
  reg  [7:0] pending;
  reg  [3:0] wait_cnt;
  wire       fire = (pending != 8'h00) && !i_stall && (wait_cnt >= i_delay);

  //////////////////////////////////////////////////
  // Each REQ transition is one request, answered by one ACK transition
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_seen       <= 1'h0;
      pending        <= 8'h00;
      wait_cnt       <= 4'h0;
      o_ack_pin      <= 1'h0;
      o_mdp_rejected <= 1'h0;
      o_abort_task   <= 1'h0;
    end else begin
      req_seen       <= i_req_pin;
      pending        <= pending + {7'h00, i_req_pin ^ req_seen} - {7'h00, fire};
      wait_cnt       <= (fire || pending == 8'h00) ? 4'h0 : wait_cnt + 4'h1;
      o_ack_pin      <= o_ack_pin ^ fire;
      o_mdp_rejected <= i_reject_cmd;
      o_abort_task   <= i_stray_reselect;
    end
  end
endmodule // tdp_initiator_model

// ===== tdp_core_tb.sv
// Self-checking bench of tdp_core with an initiator model on the bus pins.
// Assumes the checker is bound to tdp_core; the unit tick is cut to 4 cycles.
`timescale 1ns/1ps
`include "tdp_regs.vh"

module tdp_core_tb;
  localparam [15:0] Z16 = 16'h0000;
  localparam [7:0]  Z8 = 8'h00;
  reg        clk = 1'h0, rst_b = 1'h0, wr = 1'h0, cm = 1'h0, rd = 1'h0;
  reg        bsy = 1'h0, priv = 1'h0, cpd = 1'h0, dph = 1'h0, bx = 1'h0;
  reg        dd = 1'h0, cd = 1'h0, req = 1'h0, stall = 1'h0, rej = 1'h0;
  reg  [2:0] logical_unit_number = 3'h0;
  reg  [5:0] pc = 6'h00;
  reg  [3:0] idx = 4'h0;
  reg  [7:0] wd = 8'h00, r2;
  wire       ack, mrej, ok, ill, rv, ab, disc, rok, mal, mab, stt;
  wire [7:0] rdat;
  wire [3:0] evt = {stt, mab, rok, disc};
  integer    errors = 0, n_compared = 0, seed = 58626, i, t, rnd;
  reg  [1:0] q_sel[$];
  reg  [8:0] q_rd[$];

  //////////////////////////////////////////////////
  always #2.5 clk = ~clk;

  tdp_core #(.P_UNIT_CYC(16'h0004)) u_dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_logical_unit_number(logical_unit_number), .i_pg_code(pc),
    .i_pg_wr(wr), .i_pg_idx(idx), .i_pg_wdata(wd), .i_pg_commit(cm), .i_pg_rd(rd),
    .o_sel_ok(ok), .o_sel_illegal(ill), .o_pg_rdata(rdat), .o_pg_rvalid(rv),
    .o_pg_absent(ab), .i_bsy_held(bsy), .i_priv_granted(priv), .i_cmd_phase_done(cpd),
    .i_data_phase(dph), .i_byte_xfer(bx), .i_data_done(dd), .i_cmd_done(cd),
    .i_req_pin(req), .i_ack_pin(ack), .i_mdp_rejected(mrej), .o_disc_req(disc),
    .o_reconnect_ok(rok), .o_mdp_allow(mal), .o_mdp_abort(mab), .o_stt_bus_free(stt));
  tdp_initiator_model u_init (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_req_pin(req), .i_stall(stall),
    .i_delay(4'h2), .i_reject_cmd(rej), .i_stray_reselect(1'h0), .o_ack_pin(ack),
    .o_mdp_rejected(mrej), .o_abort_task());

  // Reporting and comparison
  task fail(input [15:0] got, input [15:0] exp);
    errors = errors + 1;
    $display("mismatch at %0t: got %h expected %h", $time, got, exp);
  endtask
  task cmp_sel(input [1:0] got, input [1:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) fail(got, exp);
  endtask
  task cmp_rd(input [8:0] got, input [8:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) fail(got, exp);
  endtask
  task cmp_evt(input got, input exp);
    n_compared = n_compared + 1;
    if (got !== exp) fail(got, exp);
  endtask
  task close_out;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Drivers of the page port and the phase strobes
  task step(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wrb(input [3:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    idx <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task w16(input [3:0] a, input [15:0] v);
    wrb(a, v[15:8]);
    wrb(a + 4'h1, v[7:0]);
  endtask
  task commit(input [5:0] c, input [1:0] exp);
    q_sel.push_back(exp);
    @(posedge clk);
    pc <= c;
    cm <= 1'h1;
    @(posedge clk);
    cm <= 1'h0;
  endtask
  task rdb(input [5:0] c, input [3:0] a, input [8:0] exp);
    q_rd.push_back(exp);
    @(posedge clk);
    pc <= c;
    idx <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
  endtask
  task page02(input [15:0] il, rc, oc, bs, input [7:0] fl, x, input [1:0] exp);
    rnd = $random(seed);
    r2 = rnd[7:0];
    wrb(4'h2, r2);
    w16(4'h4, il);
    w16(4'h6, rc);
    w16(4'h8, oc);
    w16(4'hA, bs);
    wrb(4'hC, fl);
    wrb(4'hD, x);
    commit(`TDP_PG_DISC, exp);
  endtask
  task bytes(input integer n);
    repeat (n) begin
      @(posedge clk);
      bx <= 1'h1;
      @(posedge clk);
      bx <= 1'h0;
    end
  endtask
  task pulse_rej;
    rej <= 1'h1;
    step(1);
    rej <= 1'h0;
  endtask
  task wait_evt(input integer sel, input integer lim, input exp);
    reg seen;
    seen = 1'h0;
    for (t = 0; t < lim && !seen; t = t + 1) begin
      @(posedge clk);
      seen = (evt[sel] === 1'h1);
    end
    cmp_evt(seen, exp);
  endtask

  // Take the oldest note off a queue whenever the design answers
  always @(posedge clk) begin
    if (ok || ill) cmp_sel({ok, ill}, q_sel.pop_front());
    if (rv) cmp_rd({ab, rdat}, q_rd.pop_front());
  end

  // Reset, page checks, then policy and timeout scenarios
  initial begin
    step(3);
    rst_b <= 1'h1;
    step(2);
    for (i = 0; i < 8; i = i + 1) begin
      page02(Z16, Z16, Z16, Z16, i[7:0], Z8, (i == 0 || i == 1 || i == 3) ? 2'h2 : 2'h1);
    end
    page02(Z16, Z16, Z16, 16'h0001, 8'h01, Z8, 2'h1);
    page02(Z16, Z16, Z16, Z16, 8'h10, Z8, 2'h1);
    page02(Z16, Z16, Z16, Z16, Z8, 8'h01, 2'h1);
    page02(Z16, 16'h0003, Z16, Z16, 8'h80, Z8, 2'h2);
    rdb(`TDP_PG_DISC, 4'h0, 9'h002);
    rdb(`TDP_PG_DISC, 4'h1, 9'h00E);
    rdb(`TDP_PG_DISC, 4'h2, {1'h0, r2});
    rdb(`TDP_PG_DISC, 4'hC, 9'h080);
    rdb(`TDP_PG_LUCTL, 4'h1, 9'h006);
    logical_unit_number <= 3'h1;
    rdb(`TDP_PG_PORT, 4'h0, 9'h100);
    logical_unit_number <= 3'h0;
    cmp_evt(mal, 1'h1);
    pulse_rej;
    wait_evt(2, 8, 1'h1);
    bsy <= 1'h1;
    step(3);
    bsy <= 1'h0;
    wait_evt(1, 8, 1'h0);
    wait_evt(1, 12, 1'h1);
    wrb(4'h3, 8'h01);
    w16(4'h4, 16'h0002);
    commit(`TDP_PG_PORT, 2'h2);
    rdb(`TDP_PG_PORT, 4'h3, 9'h001);
    rdb(`TDP_PG_PORT, 4'h5, 9'h002);
    bsy <= 1'h1;
    req <= ~req;
    wait_evt(3, 100, 1'h0);
    stall <= 1'h1;
    req <= ~req;
    wait_evt(3, 120, 1'h1);
    stall <= 1'h0;
    bsy <= 1'h0;
    priv <= 1'h1;
    page02(Z16, Z16, Z16, Z16, 8'h08, Z8, 2'h2);
    bsy <= 1'h1;
    wait_evt(0, 10, 1'h0);
    cpd <= 1'h1;
    step(1);
    cpd <= 1'h0;
    wait_evt(0, 6, 1'h1);
    bsy <= 1'h0;
    page02(Z16, Z16, Z16, 16'h0001, Z8, Z8, 2'h2);
    bsy <= 1'h1;
    dph <= 1'h1;
    bytes(511);
    wait_evt(0, 4, 1'h0);
    bytes(1);
    wait_evt(0, 6, 1'h1);
    bsy <= 1'h0;
    dph <= 1'h0;
    page02(Z16, Z16, 16'h0002, Z16, Z8, Z8, 2'h2);
    bsy <= 1'h1;
    wait_evt(0, 4, 1'h0);
    wait_evt(0, 20, 1'h1);
    bsy <= 1'h0;
    priv <= 1'h0;
    page02(16'h0001, Z16, Z16, Z16, Z8, Z8, 2'h2);
    bsy <= 1'h1;
    wait_evt(0, 20, 1'h0);
    priv <= 1'h1;
    wait_evt(0, 8, 1'h1);
    bsy <= 1'h0;
    for (i = 1; i < 4; i = i + 2) begin
      page02(Z16, Z16, 16'h0001, Z16, i[7:0], Z8, 2'h2);
      bsy <= 1'h1;
      dph <= 1'h1;
      wait_evt(0, 30, 1'h0);
      dd <= 1'h1;
      step(1);
      dd <= 1'h0;
      wait_evt(0, 8, i == 1);
      cd <= 1'h1;
      step(1);
      cd <= 1'h0;
      wait_evt(0, 8, 1'h1);
      bsy <= 1'h0;
      dph <= 1'h0;
    end
    cmp_evt(mal, 1'h0);
    pulse_rej;
    wait_evt(2, 8, 1'h0);
    step(4);
    close_out;
  end

  // Cut a hung run short well past the expected span of some 1800 cycles
  initial begin
    #100000;
    errors = errors + 1;
    close_out;
  end
endmodule // tdp_core_tb
